// file: verilog/vsbm_map.vh
// register map, field positions, reset values and codes of the vme slave bridge
// assumes plain verilog-2005 and inclusion by bare name
`ifndef VSBM_MAP_VH
`define VSBM_MAP_VH
// global registers, byte addresses on the ahb-lite port
`define VSBM_MODE_OFS      12'h000
`define VSBM_RETRY_OFS     12'h004
`define VSBM_RERUN_OFS     12'h008
`define VSBM_CAP_OFS       12'h00c
`define VSBM_SHORT_OFS     12'h010
`define VSBM_STAT_OFS      12'h014
// window sets start at 0x040, stride 0x040, set index = addr[7:6]-1
`define VSBM_SET_FIRST     2'h1
`define VSBM_F_CTRL        4'h0
`define VSBM_F_A24_BASE    4'h1
`define VSBM_F_A24_SIZE    4'h2
`define VSBM_F_A24_TGT     4'h3
`define VSBM_F_A24_TSIZE   4'h4
`define VSBM_F_A32_BASE    4'h5
`define VSBM_F_A32_SIZE    4'h6
`define VSBM_F_A32_TGT     4'h7
`define VSBM_F_A32_TSIZE   4'h8
// mode register fields
`define VSBM_M_BLEN_LO     0
`define VSBM_M_STOP_LO     2
`define VSBM_M_BURST       4
`define VSBM_M_HARB        5
`define VSBM_M_SPLIT       6
`define VSBM_M_SFLOW       7
`define VSBM_M_RERUN       8
`define VSBM_MODE_RST      9'h000
`define VSBM_RETRY_RST     8'hff
`define VSBM_RERUN_RST     8'hff
// short window register: base in [15:0], enable in bit 16
`define VSBM_SHORT_EN      16
`define VSBM_SHORT_MASK    16'hfe00
// window set control fields
`define VSBM_C_DEC         0
`define VSBM_C_WP          1
// vme address space codes
`define VSBM_SP_A16        2'h0
`define VSBM_SP_A24        2'h1
`define VSBM_SP_A32        2'h2
`endif

// file: verilog/vsbm_bridge.v
// vme slave to sbus master bridge: ahb-lite registers, window decode, sbus cycle control
// assumes vme address/data/space/write are stable while the strobe is low and that
// the sbus side answers with same-clock one-cycle ack or err pulses
//
// Overview of operation
// - read bursts stop at 8/16/32/64 byte boundary chosen by a two-bit code
// - sbus cycle ends with retry after programmed count of sbus clocks, 0..255
// - reruns issued only while rerun enable is set, never otherwise
// - reruns counted; cycle ends with error once rerun ceiling reached
// - burst transfers only while burst enable set, else single transfers
// - hidden arbitration only while its enable is set
// - split and split flowthrough each used only while own enable set
// - readable capability register shows split, flowthrough, hidden arbitration and burst enables, stop point and burst length
// - three window sets, each opening a 24-bit and a 32-bit window
// - wide windows reach memory; short window reaches only bridge registers
// - short-space accesses answered only while short window enabled
// - short window base ignores its lowest nine bits, 512-byte aligned
// - each set decodes only while its own decode enable is set
// - writes posted on vme only while that set's posting enable is set
// - each set claims 24-bit accesses inside its base and size and below its target size
// - claimed 24-bit accesses map into the set's sbus target range
// - each set holds a readable 32-bit window size
// - bridge is vme slave and sbus initiating master while serving
// - generated bursts capped by two-bit code 8/16/32/64 bytes
// - claimed 32-bit accesses map into the set's 32-bit sbus range
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`include "vsbm_map.vh"
module vsbm_bridge (
    input  wire        clk,
    input  wire        sys_rst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // vme slave side
    input  wire        vme_as_n,
    input  wire [31:0] vme_addr,
    input  wire [1:0]  vme_space,
    input  wire        vme_write,
    input  wire [31:0] vme_wdata,
    output reg  [31:0] vme_rdata,
    output reg         vme_dtack_n,
    output reg         vme_berr_n,
    // sbus master side
    output reg         sb_req,
    output reg  [31:0] sb_addr,
    output reg         sb_write,
    output reg  [31:0] sb_wdata,
    output reg         sb_burst,
    output reg  [1:0]  sb_len,
    output reg  [1:0]  sb_stop,
    output reg         sb_hidden_arb,
    output reg         sb_split,
    output reg         sb_split_flow,
    output reg         sb_rerun,
    output reg         sb_retry,
    input  wire        sb_ack,
    input  wire        sb_err,
    input  wire [31:0] sb_rdata
);
    localparam NSET = 3;
    localparam [4:0] ST_IDLE = 5'h01, ST_REG = 5'h02, ST_SBUS = 5'h04,
                     ST_GAP = 5'h08, ST_REL = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [8:0]  mode;
    reg [7:0]  retry_time;
    reg [7:0]  rerun_limit;
    reg [16:0] short_win;
    reg [1:0]  set_ctrl  [0:NSET-1];
    reg [31:0] a24_base  [0:NSET-1];
    reg [31:0] a24_size  [0:NSET-1];
    reg [31:0] a24_tgt   [0:NSET-1];
    reg [31:0] a24_tsize [0:NSET-1];
    reg [31:0] a32_base  [0:NSET-1];
    reg [31:0] a32_size  [0:NSET-1];
    reg [31:0] a32_tgt   [0:NSET-1];
    reg [31:0] a32_tsize [0:NSET-1];
    reg        last_err;
    reg        last_retry;
    reg [4:0]  state;
    reg [7:0]  retry_cnt;
    reg [7:0]  rerun_cnt;

    // ahb address phase capture
    reg        ap_wr;
    reg [11:0] ap_addr;
    wire       ahb_take = hsel & htrans[1] & hready;

    // vme strobe synchroniser, a change counts once stages 2 and 3 agree
    reg as_s1, as_s2, as_s3, as_on;
    always @(posedge clk) begin
        if (sys_rst) begin
            as_s1 <= 1'b1;
            as_s2 <= 1'b1;
            as_s3 <= 1'b1;
            as_on <= 1'b0;
        end else begin
            as_s1 <= vme_as_n;
            as_s2 <= as_s1;
            as_s3 <= as_s2;
            if (as_s2 == as_s3)
                as_on <= ~as_s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read mux, shared by ahb and the short vme window
    function [31:0] rd_reg;
        input [11:0] a;
        reg   [1:0]  s;
        begin
            rd_reg = 32'h0;
            s = a[7:6] - `VSBM_SET_FIRST;
            if (a[11:8] == 4'h0 && a[7:6] != 2'h0 && a[5:2] <= `VSBM_F_A32_TSIZE) begin
                case (a[5:2])
                    `VSBM_F_CTRL:      rd_reg = {30'h0, set_ctrl[s]};
                    `VSBM_F_A24_BASE:  rd_reg = a24_base[s];
                    `VSBM_F_A24_SIZE:  rd_reg = a24_size[s];
                    `VSBM_F_A24_TGT:   rd_reg = a24_tgt[s];
                    `VSBM_F_A24_TSIZE: rd_reg = a24_tsize[s];
                    `VSBM_F_A32_BASE:  rd_reg = a32_base[s];
                    `VSBM_F_A32_SIZE:  rd_reg = a32_size[s];
                    `VSBM_F_A32_TGT:   rd_reg = a32_tgt[s];
                    default:           rd_reg = a32_tsize[s];
                endcase
            end else if (a == `VSBM_MODE_OFS)
                rd_reg = {23'h0, mode};
            else if (a == `VSBM_RETRY_OFS)
                rd_reg = {24'h0, retry_time};
            else if (a == `VSBM_RERUN_OFS)
                rd_reg = {24'h0, rerun_limit};
            else if (a == `VSBM_CAP_OFS)
                rd_reg = {24'h0, mode[`VSBM_M_SPLIT], mode[`VSBM_M_SFLOW],
                          mode[`VSBM_M_HARB], mode[`VSBM_M_BURST],
                          mode[3:2], mode[1:0]};
            else if (a == `VSBM_SHORT_OFS)
                rd_reg = {15'h0, short_win};
            else if (a == `VSBM_STAT_OFS)
                rd_reg = {14'h0, rerun_cnt, retry_cnt, last_retry, last_err};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // latched vme request
    reg [31:0] req_addr;
    reg [1:0]  req_space;
    reg        req_write;
    reg [31:0] req_wdata;
    reg        posted;

    // per-set window decode and translation
    wire [NSET-1:0] hit24;
    wire [NSET-1:0] hit32;
    wire [31:0]     xl24 [0:NSET-1];
    wire [31:0]     xl32 [0:NSET-1];
    genvar g;
    generate
        for (g = 0; g < NSET; g = g + 1) begin : g_win
            wire [31:0] off24 = {8'h0, req_addr[23:0]} - a24_base[g];
            wire [31:0] off32 = req_addr - a32_base[g];
            // a window claims only while its decode enable is set
            assign hit24[g] = set_ctrl[g][`VSBM_C_DEC] & (req_space == `VSBM_SP_A24)
                            & ({8'h0, req_addr[23:0]} >= a24_base[g])
                            & (off24 < a24_size[g]) & (off24 < a24_tsize[g]);
            assign hit32[g] = set_ctrl[g][`VSBM_C_DEC] & (req_space == `VSBM_SP_A32)
                            & (req_addr >= a32_base[g])
                            & (off32 < a32_size[g]) & (off32 < a32_tsize[g]);
            assign xl24[g] = a24_tgt[g] + off24;
            assign xl32[g] = a32_tgt[g] + off32;
        end
    endgenerate

    // lowest numbered matching set wins
    reg        any_hit;
    reg [31:0] hit_addr;
    reg        hit_wp;
    integer    k;
    always @* begin
        any_hit  = 1'b0;
        hit_addr = 32'h0;
        hit_wp   = 1'b0;
        for (k = NSET - 1; k >= 0; k = k - 1) begin
            if (hit24[k] | hit32[k]) begin
                any_hit  = 1'b1;
                hit_addr = hit24[k] ? xl24[k] : xl32[k];
                hit_wp   = set_ctrl[k][`VSBM_C_WP];
            end
        end
    end

    // short window: registers only, 512-byte aligned base
    wire short_hit = short_win[`VSBM_SHORT_EN] & (req_space == `VSBM_SP_A16)
                   & ((req_addr[15:0] & `VSBM_SHORT_MASK)
                      == (short_win[15:0] & `VSBM_SHORT_MASK));
    wire vme_reg_wr = (state == ST_REG) & req_write & ~ap_wr;

    ////////////////////////////////////////////////////////////////////////
    // register writes; an ahb write stalls a concurrent short-window write
    reg [11:0] w_addr;
    reg [31:0] w_data;
    reg        w_en;
    reg [1:0]  w_set;
    always @* begin
        w_en   = ap_wr | vme_reg_wr;
        w_addr = ap_wr ? ap_addr : {3'h0, req_addr[8:0]};
        w_data = ap_wr ? hwdata : req_wdata;
        w_set  = w_addr[7:6] - `VSBM_SET_FIRST;
    end

    integer i;
    always @(posedge clk) begin
        if (sys_rst) begin
            mode        <= `VSBM_MODE_RST;
            retry_time  <= `VSBM_RETRY_RST;
            rerun_limit <= `VSBM_RERUN_RST;
            short_win   <= 17'h0;
            for (i = 0; i < NSET; i = i + 1) begin
                set_ctrl[i]  <= 2'h0;
                a24_base[i]  <= 32'h0;
                a24_size[i]  <= 32'h0;
                a24_tgt[i]   <= 32'h0;
                a24_tsize[i] <= 32'h0;
                a32_base[i]  <= 32'h0;
                a32_size[i]  <= 32'h0;
                a32_tgt[i]   <= 32'h0;
                a32_tsize[i] <= 32'h0;
            end
        end else if (w_en) begin
            if (w_addr[11:8] == 4'h0 && w_addr[7:6] != 2'h0) begin
                case (w_addr[5:2])
                    `VSBM_F_CTRL:      set_ctrl[w_set]  <= w_data[1:0];
                    `VSBM_F_A24_BASE:  a24_base[w_set]  <= {8'h0, w_data[23:0]};
                    `VSBM_F_A24_SIZE:  a24_size[w_set]  <= w_data;
                    `VSBM_F_A24_TGT:   a24_tgt[w_set]   <= w_data;
                    `VSBM_F_A24_TSIZE: a24_tsize[w_set] <= w_data;
                    `VSBM_F_A32_BASE:  a32_base[w_set]  <= w_data;
                    `VSBM_F_A32_SIZE:  a32_size[w_set]  <= w_data;
                    `VSBM_F_A32_TGT:   a32_tgt[w_set]   <= w_data;
                    `VSBM_F_A32_TSIZE: a32_tsize[w_set] <= w_data;
                    default: ;
                endcase
            end else if (w_addr == `VSBM_MODE_OFS)
                mode <= w_data[8:0];
            else if (w_addr == `VSBM_RETRY_OFS)
                retry_time <= w_data[7:0]; // floor is software's job
            else if (w_addr == `VSBM_RERUN_OFS)
                rerun_limit <= w_data[7:0];
            else if (w_addr == `VSBM_SHORT_OFS)
                short_win <= {w_data[16], w_data[15:9], 9'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always okay, unmapped reads zero
    always @(posedge clk) begin
        if (sys_rst) begin
            ap_wr     <= 1'b0;
            ap_addr   <= 12'h0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ap_wr     <= ahb_take & hwrite;
            ap_addr   <= haddr;
            hrdata    <= (ahb_take & ~hwrite) ? rd_reg(haddr) : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vme request state machine; serving makes us vme slave and sbus master
    wire retry_due = (retry_cnt == retry_time);
    always @(posedge clk) begin
        if (sys_rst) begin
            state       <= ST_IDLE;
            req_addr    <= 32'h0;
            req_space   <= 2'h0;
            req_write   <= 1'b0;
            req_wdata   <= 32'h0;
            posted      <= 1'b0;
            vme_rdata   <= 32'h0;
            vme_dtack_n <= 1'b1;
            vme_berr_n  <= 1'b1;
            sb_req      <= 1'b0;
            sb_addr     <= 32'h0;
            sb_write    <= 1'b0;
            sb_wdata    <= 32'h0;
            sb_burst    <= 1'b0;
            sb_len      <= 2'h0;
            sb_stop     <= 2'h0;
            sb_rerun    <= 1'b0;
            sb_retry    <= 1'b0;
            retry_cnt   <= 8'h0;
            rerun_cnt   <= 8'h0;
            last_err    <= 1'b0;
            last_retry  <= 1'b0;
            sb_hidden_arb <= 1'b0;
            sb_split      <= 1'b0;
            sb_split_flow <= 1'b0;
        end else begin
            sb_rerun <= 1'b0;
            sb_retry <= 1'b0;
            sb_hidden_arb <= mode[`VSBM_M_HARB];
            sb_split      <= mode[`VSBM_M_SPLIT];
            sb_split_flow <= mode[`VSBM_M_SFLOW];
            case (state)
                ST_IDLE: begin
                    // inputs are stable once the strobe has settled low
                    if (as_on) begin
                        req_addr  <= vme_addr;
                        req_space <= vme_space;
                        req_write <= vme_write;
                        req_wdata <= vme_wdata;
                        state     <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // decode from latched request, one cycle after capture
                    if (short_hit)
                        state <= ST_REG;
                    else if (any_hit) begin
                        sb_req    <= 1'b1;
                        sb_addr   <= hit_addr;
                        sb_write  <= req_write;
                        sb_wdata  <= req_wdata;
                        sb_burst  <= mode[`VSBM_M_BURST];
                        sb_len    <= mode[`VSBM_M_BURST] ? mode[1:0] : 2'h0;
                        sb_stop   <= mode[3:2];
                        retry_cnt <= 8'h0;
                        rerun_cnt <= 8'h0;
                        posted    <= req_write & hit_wp;
                        if (req_write & hit_wp)
                            vme_dtack_n <= 1'b0;
                        state     <= ST_SBUS;
                    end else
                        state <= ST_REL;
                end
                ST_REG: begin
                    // register access only, never memory; a write waits out ahb writes
                    if (~req_write | ~ap_wr) begin
                        vme_rdata   <= rd_reg({3'h0, req_addr[8:0]});
                        vme_dtack_n <= 1'b0;
                        state       <= ST_REL;
                    end
                end
                ST_SBUS: begin
                    if (sb_ack | sb_err) begin
                        sb_req     <= 1'b0;
                        last_err   <= sb_err;
                        last_retry <= 1'b0;
                        vme_rdata  <= sb_rdata;
                        if (!posted) begin
                            vme_dtack_n <= ~sb_ack;
                            vme_berr_n  <= ~sb_err;
                        end
                        state <= ST_REL;
                    end else if (retry_due) begin
                        sb_retry <= 1'b1;
                        if (mode[`VSBM_M_RERUN] && rerun_cnt != rerun_limit) begin
                            sb_rerun  <= 1'b1;
                            rerun_cnt <= rerun_cnt + 8'h1;
                            retry_cnt <= 8'h0;
                        end else begin
                            // ceiling reached or reruns off: end with error
                            sb_req     <= 1'b0;
                            last_err   <= mode[`VSBM_M_RERUN];
                            last_retry <= 1'b1;
                            if (!posted)
                                vme_berr_n <= 1'b0;
                            state <= ST_REL;
                        end
                    end else
                        retry_cnt <= retry_cnt + 8'h1;
                end
                ST_REL: begin
                    // hold the answer until the master lifts its strobe
                    if (!as_on) begin
                        vme_dtack_n <= 1'b1;
                        vme_berr_n  <= 1'b1;
                        state       <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// file: test/vsbm_monitor.sv
// assertion checker of the vme slave bridge, bound to its top module
// assumes one clock domain with a synchronous active high reset
module vsbm_monitor (
    input logic        clk,
    input logic        sys_rst,
    input logic        vme_as_n,
    input logic [31:0] vme_rdata,
    input logic        vme_dtack_n,
    input logic        vme_berr_n,
    input logic        sb_req,
    input logic [31:0] sb_addr,
    input logic        sb_write,
    input logic        sb_burst,
    input logic [1:0]  sb_len,
    input logic        sb_rerun,
    input logic        sb_retry,
    input logic        sb_ack,
    input logic        sb_err,
    input logic [31:0] sb_rdata
);
default clocking mon_cb @(posedge clk); endclocking
default disable iff (sys_rst);
////////////////////////////////////////////////////////////////////////////////
// steps of an sbus cycle as seen at the pins
sequence s_rd_ack;
    sb_req && sb_ack && !sb_write;
endsequence
sequence s_rd_err;
    sb_req && sb_err && !sb_ack && !sb_write;
endsequence
property p_rd_done;
    s_rd_ack |=> !vme_dtack_n && !sb_req && vme_rdata == $past(sb_rdata);
endproperty
property p_err_done;
    s_rd_err |=> !vme_berr_n && !sb_req;
endproperty
property p_retry_in;
    sb_retry |-> $past(sb_req);
endproperty
property p_give_up;
    sb_retry && !sb_rerun |=> !sb_req;
endproperty
property p_rerun_keep;
    sb_rerun |-> sb_retry ##1 sb_req;
endproperty
property p_restart;
    sb_rerun |=> !sb_retry;
endproperty
property p_single;
    sb_req && !sb_burst |-> sb_len == 2'h0;
endproperty
property p_hold;
    sb_req ##1 sb_req |-> $stable(sb_addr) && $stable(sb_write) && $stable(sb_burst);
endproperty
property p_ans_held;
    !vme_as_n && !vme_dtack_n |=> !vme_dtack_n;
endproperty
property p_idle_quiet;
    vme_as_n [*6] |-> vme_dtack_n && vme_berr_n;
endproperty
////////////////////////////////////////////////////////////////////////////////
a_rd_done: assert property (p_rd_done) else $error("read ack not passed on");
a_err_done: assert property (p_err_done) else $error("target error not passed on");
a_retry_in: assert property (p_retry_in) else $error("retry outside a cycle");
a_give_up: assert property (p_give_up) else $error("cycle kept without rerun");
a_rerun_keep: assert property (p_rerun_keep) else $error("rerun ended the cycle");
a_restart: assert property (p_restart) else $error("retry count not restarted");
a_single: assert property (p_single) else $error("burst length with bursts off");
a_hold: assert property (p_hold) else $error("cycle fields moved");
a_ans_held: assert property (p_ans_held) else $error("dtack dropped early");
a_idle_quiet: assert property (p_idle_quiet) else $error("answer without strobe");
endmodule
bind vsbm_bridge vsbm_monitor u_mon (.*);

// file: test/vsbm_sbus_target.sv
// sbus target model: answers a cycle after dly waiting clocks
// assumes mode 0 ack, 1 error, 2 never answers (forces retries)
module vsbm_sbus_target (
    input  logic        clk,
    input  logic        sys_rst,
    input  logic        sb_req,
    input  logic [31:0] sb_addr,
    input  logic        sb_rerun,
    input  logic [7:0]  dly,
    input  logic [1:0]  mode,
    output logic        sb_ack,
    output logic        sb_err,
    output logic [31:0] sb_rdata
);
logic [7:0]  cnt;
logic [31:0] pat;
// a rerun restarts the wait like a fresh cycle
always @(posedge clk) begin
    if (sys_rst || !sb_req || sb_rerun || sb_ack || sb_err)
        cnt <= 8'h00;
    else
        cnt <= cnt + 8'h01;
    pat <= sys_rst ? 32'h0f0f_0f0f : ~pat;
end
// data lines not driven show a toggling pattern, never a stale word
always @* begin
    sb_ack   = sb_req && cnt == dly && mode == 2'h0;
    sb_err   = sb_req && cnt == dly && mode == 2'h1;
    sb_rdata = sb_ack ? sb_addr ^ 32'h5a5a_5a5a : pat;
end
endmodule

// file: test/vsbm_bridge_tb_top.sv
// testbench of the vme slave bridge: registers, windows, sbus cycle control
// assumes the bridge, its monitor and the sbus target model are compiled first
module vsbm_bridge_tb_top;
timeunit 1ns;
timeprecision 1ps;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
typedef struct { logic [11:0] a; logic [31:0] d; logic [31:0] e; } vsbm_row_t;
localparam int MIN_RETRY = 2;  // floor of the retry time, plain default
localparam int MIN_RERUN = 1;  // floor of the rerun ceiling, plain default
logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp, vme_as_n, vme_write, pend;
logic        vme_dtack_n, vme_berr_n, sb_req, sb_write, sb_burst, sb_hidden_arb;
logic        sb_split, sb_split_flow, sb_rerun, sb_retry, sb_ack, sb_err;
logic [1:0]  htrans, vme_space, sb_len, sb_stop, res, tg_mode;
logic [2:0]  hsize;
logic [4:0]  s_attr;
logic [7:0]  tg_dly;
logic [11:0] haddr;
logic [31:0] hwdata, hrdata, vme_addr, vme_wdata, vme_rdata, sb_addr, sb_wdata;
logic [31:0] sb_rdata, q, s_addr;
logic [43:0] cfg [10];
int          n_fail, checks_done, cyc, n_cyc, n_rt, n_rr, n0;
wire         hready = hreadyout;
vsbm_row_t   rows [8];
vsbm_bridge dut (.*);
vsbm_sbus_target u_tgt (.clk, .sys_rst, .sb_req, .sb_addr, .sb_rerun, .dly(tg_dly),
    .mode(tg_mode), .sb_ack, .sb_err, .sb_rdata);
////////////////////////////////////////////////////////////////////////////////
// clock, sbus cycle log and hang guard
initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
always @(posedge clk) begin
    cyc++;
    if ($rose(sb_req)) begin
        n_cyc++;
        s_addr = sb_addr;
        s_attr = {sb_burst, sb_len, sb_stop};
    end
    n_rt += int'(sb_retry);
    n_rr += int'(sb_rerun);
    if (cyc == 30000) begin
        n_fail++;
        finish_test;
    end
end
////////////////////////////////////////////////////////////////////////////////
task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
// one ahb-lite word; held until ready is sampled high at a rising edge
task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge clk); while (!hready);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (!hready);
    q = hrdata;
endtask
// vme strobe held until answered or given up
task automatic vme(input logic [1:0] sp, input logic [31:0] a, input logic w);
    int k;
    vme_space <= sp;
    vme_addr <= a;
    vme_write <= w;
    vme_wdata <= ~a;
    vme_as_n <= 1'b0;
    k = 0;
    do begin @(negedge clk); k++; end while (vme_dtack_n && vme_berr_n && k < 80);
    res = !vme_dtack_n ? 2'h0 : (!vme_berr_n ? 2'h1 : 2'h2);
    q = vme_rdata;
    pend = sb_req;
    @(posedge clk);
    vme_as_n <= 1'b1;
    vme_space <= 2'h3;
    vme_addr <= ~a;
    vme_wdata <= a;
    repeat (8) @(posedge clk);
    `CHK("vme release", 2'h3, {vme_dtack_n, vme_berr_n})
endtask
// software: modulo 256, never below floor
function automatic logic [31:0] floor8(int v, int m);
    return (v % 256 < m) ? m : v % 256;
endfunction
////////////////////////////////////////////////////////////////////////////////
initial begin
    rows = '{'{12'h000, 32'h1ff, 32'h1ff}, '{12'h00c, 32'h0, 32'hff},
        '{12'h004, 32'h123, 32'h23}, '{12'h008, 32'haff, 32'hff},
        '{12'h010, 32'h1_ffff, 32'h1_fe00}, '{12'h020, 32'hffff_ffff, 32'h0},
        '{12'h058, 32'h1000, 32'h1000}, '{12'h0c4, 32'hffc0_0000, 32'hc0_0000}};
    cfg = '{{12'h044, 32'h10_0000}, {12'h048, 32'h1_0000}, {12'h04c, 32'h8000_0000},
        {12'h050, 32'h1_0000}, {12'h040, 32'h1}, {12'h094, 32'h2340_0000},
        {12'h098, 32'h20_0000}, {12'h09c, 32'hffe0_0000}, {12'h0a0, 32'h20_0000},
        {12'h080, 32'h1}};
    {hsel, htrans, haddr, hwrite, hwdata, vme_addr, vme_write, vme_wdata} = '0;
    {sys_rst, vme_as_n, vme_space, hsize, tg_dly, tg_mode} = {1'b1, 1'b1, 2'h3, 3'h2, 8'h3, 2'h0};
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // ordinary register cases: write, then read back
    foreach (rows[i]) begin
        ahb(1'b1, rows[i].a, rows[i].d);
        ahb(1'b0, rows[i].a, 32'h0);
        `CHK("register", rows[i].e, q)
    end
    // reset in mid-run brings back the documented defaults
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) if (i < 5) begin
        ahb(1'b0, rows[i].a, 32'h0);
        `CHK("reset value", (i == 2 || i == 3) ? 32'hff : 32'h0, q)
    end
    // each of mode bits 5 to 7 reaches only its own pin
    for (int b = 5; b < 8; b++) begin
        ahb(1'b1, 12'h000, 32'h1 << b);
        repeat (2) @(posedge clk);
        `CHK("mode pins", 3'h1 << (b - 5), {sb_split_flow, sb_split, sb_hidden_arb})
    end
    foreach (cfg[i]) ahb(1'b1, cfg[i][43:32], cfg[i][31:0]);
    ahb(1'b1, 12'h004, floor8(260, MIN_RETRY));
    ahb(1'b1, 12'h008, floor8(258, MIN_RERUN));
    // every stop and length code, bursts on and off, through window set 0
    for (int c = 0; c < 8; c++) begin
        ahb(1'b1, 12'h000, {c[2], c[1:0], c[1:0]});
        vme(2'h1, 32'h10_0040 + c * 4, 1'b0);
        `CHK("a24 answer", 2'h0, res)
        `CHK("a24 data", (32'h8000_0040 + c * 4) ^ 32'h5a5a_5a5a, q)
        `CHK("a24 target", 32'h8000_0040 + c * 4, s_addr)
        `CHK("attributes", {c[2], c[2] ? c[1:0] : 2'h0, c[1:0]}, s_attr)
    end
    vme(2'h2, 32'h2340_0100, 1'b0);
    `CHK("a32 target", 32'hffe0_0100, s_addr)
    // posted write answers early, unposted after; target beats the retry time
    tg_dly <= 8'h02;
    for (int p = 0; p < 2; p++) begin
        ahb(1'b1, 12'h040, p ? 32'h1 : 32'h3);
        vme(2'h1, 32'h10_0080, 1'b1);
        `CHK("write posting", {2'h0, p == 0}, {res, pend})
    end
    // miss and disabled set: no answer, no cycle
    n0 = n_cyc;
    vme(2'h1, 32'h30_0000, 1'b0);
    `CHK("miss", 2'h2, res)
    ahb(1'b1, 12'h040, 32'h0);
    vme(2'h1, 32'h10_0040, 1'b0);
    `CHK("set off", {2'h2, n0}, {res, n_cyc})
    vme(2'h2, 32'h2340_0100, 1'b0);
    `CHK("other set", 2'h0, res)
    // silent target: retry alone, then reruns up to the ceiling
    tg_mode <= 2'h2;
    for (int i = 0; i < 4; i++) begin
        ahb(1'b1, 12'h000, {i[1], 8'h0});
        {n_rt, n_rr} = '0;
        vme(2'h2, 32'h2340_0200, 1'b0);
        `CHK("retry end", 2'h1, res)
        `CHK("retries", i[1] ? 3 : 1, n_rt)
        `CHK("reruns", i[1] ? 2 : 0, n_rr)
    end
    tg_mode <= 2'h1;
    vme(2'h2, 32'h2340_0300, 1'b0);
    `CHK("target error", 2'h1, res)
    // short window: off, then on at a base with low bits dropped
    n0 = n_cyc;
    vme(2'h0, 32'h1204, 1'b0);
    `CHK("short off", 2'h2, res)
    ahb(1'b1, 12'h010, 32'h1_1234);
    vme(2'h0, 32'h1204, 1'b0);
    `CHK("short read", {2'h0, 32'h4, n0}, {res, q, n_cyc})
    vme(2'h0, 32'h1004, 1'b0);
    `CHK("short miss", 2'h2, res)
    finish_test;
end
endmodule
